/* File: src/gcpa_pkg.sv */
// Register map, field layout and reset values of the global control block
package gcpa_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PWR = 8'h01;
    localparam logic [7:0] IDX_SUM = 8'h02;
    localparam logic [7:0] IDX_FMT = 8'h03;
    localparam logic [7:0] IDX_CLK = 8'h04;
    localparam logic [7:0] IDX_IST = 8'h08;
    localparam logic [7:0] IDX_IMSK = 8'h09;
    localparam logic [7:0] ADDR_PWR = 8'h04;
    localparam logic [7:0] ADDR_SUM = 8'h08;
    localparam logic [7:0] ADDR_FMT = 8'h0c;
    localparam logic [7:0] ADDR_CLK = 8'h10;
    localparam logic [7:0] ADDR_IST = 8'h20;
    localparam logic [7:0] ADDR_IMSK = 8'h24;
    // Power-down and soft reset fields
    localparam int PWR_CONV = 0;
    localparam int PWR_RX = 1;
    localparam int PWR_TX = 2;
    localparam int PWR_PB = 3;
    localparam int PWR_PA = 4;
    localparam int PWR_ALL = 5;
    localparam int PWR_SRST = 7;
    // Summary and interrupt bits
    localparam int SUM_CONV = 0;
    localparam int SUM_RX = 1;
    localparam int SUM_TX = 2;
    // Port A format register fields
    localparam int FMT_LSB = 0;
    localparam int FMT_MASTER = 3;
    localparam int FMT_SEL_LSB = 4;
    localparam int FMT_MUTE = 6;
    // Port A clock register fields
    localparam int CLK_DIV_LSB = 0;
    localparam int CLK_SRC_LSB = 2;
    // Reset values
    localparam logic [6:0] PWR_RST = 7'h00;
    localparam logic [6:0] FMT_RST = 7'h00;
    localparam logic [3:0] CLK_RST = 4'h0;
    localparam logic [2:0] IMSK_RST = 3'h0;
    // Frame clock position in the bit counter: 64 bits per frame
    localparam int BIT_CNT_W = 6;
    localparam int FRAME_BIT = 5;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        GCPA_SRC_MCLK,
        GCPA_SRC_RECEIVER_CLOCK_INPUT,
        GCPA_SRC_RECOV,
        GCPA_SRC_RSVD
    } gcpa_clk_src_t;
    typedef enum logic [1:0] {
        GCPA_OUT_LOOP,
        GCPA_OUT_PORTB,
        GCPA_OUT_RX,
        GCPA_OUT_CONV
    } gcpa_out_sel_t;
endpackage

/* File: src/gcpa_ctrl.sv */
// Global power, soft reset, interrupt summary and port A control with AXI4-Lite slave
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// - Receiver held off, outputs low until enabled
// - Transmitter held off, outputs low until enabled
// - Port B held off, outputs low until enabled
// - Port A held off, outputs low until enabled
// - Global bit gates all blocks, registers live
// - Soft reset bit restores all register defaults
// - Summary read-only: converter, receiver, transmitter bits
// - Three-bit format code selects port A format
// - One format setting for input and output
// - Master mode drives frame and bit clocks
// - Output select: loopback, port B, receiver, converter
// - Mute holds port A serial output low
// - Frame clock divides master clock 128..512
// - Bit clock is 64 times frame clock
// - Master clock source select, code 3 reserved
module gcpa_ctrl import gcpa_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic conv_irq_i,
    input wire logic rx_irq_i,
    input wire logic tx_irq_i,
    input wire logic mclk_i,
    input wire logic receiver_clock_input_i,
    input wire logic recovered_clock_output_i,
    input wire logic port_a_serial_in_i,
    input wire logic port_b_serial_in_i,
    input wire logic rx_data_i,
    input wire logic conv_data_i,
    input wire logic port_a_frame_clock_i,
    input wire logic port_a_bit_clock_i,
    output logic port_a_frame_clock_o,
    output logic port_a_frame_clock_oe_n_o,
    output logic port_a_bit_clock_o,
    output logic port_a_bit_clock_oe_n_o,
    output logic port_a_serial_out_o,
    output logic [2:0] port_a_format_o,
    output logic converter_run_enable_o,
    output logic receiver_run_enable_o,
    output logic transmitter_run_enable_o,
    output logic port_b_run_enable_o,
    output logic port_a_run_enable_o,
    output logic irq_o
);
    logic aw_rdy_ff, w_rdy_ff, aw_got_ff, w_got_ff, bvalid_ff;
    logic [7:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb_ff;
    logic [1:0] bresp_ff;
    logic ar_rdy_ff, rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [6:0] pwr_ff;
    logic [6:0] fmt_ff;
    logic [3:0] clk_ff;
    logic [2:0] imsk_ff;
    logic [2:0] ist_ff;
    logic [2:0] sum_ff;
    logic [2:0] sum_prev_ff;
    logic conv_run_ff, rx_run_ff, tx_run_ff, pb_run_ff, pa_run_ff, irq_ff;
    logic src_lvl_ff, src_prev_ff;
    logic [2:0] hb_cnt_ff;
    logic bck_ff;
    logic [BIT_CNT_W-1:0] bit_cnt_ff;
    logic frame_o_ff, bck_o_ff, frame_oen_ff, bck_oen_ff, sdo_ff;
    logic wr_do, ar_hs, sw_rst, wr_ok, pa_on, pa_master, mclk_edge;
    logic [2:0] half_max;
    logic [7:0] rd_byte;
    logic rd_ok, ist_rd, nxt_sdo, nxt_src;

    assign wr_do = aw_got_ff && w_got_ff && !bvalid_ff;
    assign ar_hs = s_axi_arvalid_i && ar_rdy_ff;
    assign wr_ok = (awaddr_ff == ADDR_PWR) || (awaddr_ff == ADDR_SUM) || (awaddr_ff == ADDR_FMT)
        || (awaddr_ff == ADDR_CLK) || (awaddr_ff == ADDR_IST) || (awaddr_ff == ADDR_IMSK);
    // Soft reset acts like the reset pin on every control register
    assign sw_rst = wr_do && wstrb_ff && (awaddr_ff == ADDR_PWR) && wdata_ff[PWR_SRST];
    assign pa_on = pwr_ff[PWR_PA] && pwr_ff[PWR_ALL];
    assign pa_master = fmt_ff[FMT_MASTER];

    // Write channel: address and data taken in either order
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_rdy_ff <= 1'b1;
            w_rdy_ff <= 1'b1;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            wstrb_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && aw_rdy_ff) begin
                aw_got_ff <= 1'b1;
                aw_rdy_ff <= 1'b0;
                awaddr_ff <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && w_rdy_ff) begin
                w_got_ff <= 1'b1;
                w_rdy_ff <= 1'b0;
                wdata_ff <= s_axi_wdata_i[7:0];
                wstrb_ff <= s_axi_wstrb_i[0];
            end
            if (wr_do) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_ff && s_axi_bready_i) begin
                bvalid_ff <= 1'b0;
                aw_rdy_ff <= 1'b1;
                w_rdy_ff <= 1'b1;
            end
        end
    end

    // Register writes; upper byte lanes carry nothing
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwr_ff <= PWR_RST;
            fmt_ff <= FMT_RST;
            clk_ff <= CLK_RST;
            imsk_ff <= IMSK_RST;
        end else if (sw_rst) begin
            pwr_ff <= PWR_RST;
            fmt_ff <= FMT_RST;
            clk_ff <= CLK_RST;
            imsk_ff <= IMSK_RST;
        end else if (wr_do && wstrb_ff) begin
            if (awaddr_ff == ADDR_PWR) begin
                pwr_ff <= {wdata_ff[6], wdata_ff[5:0]} & 7'h3f;
            end else if (awaddr_ff == ADDR_FMT) begin
                fmt_ff <= wdata_ff[6:0];
            end else if (awaddr_ff == ADDR_CLK) begin
                clk_ff <= wdata_ff[3:0];
            end else if (awaddr_ff == ADDR_IMSK) begin
                imsk_ff <= wdata_ff[2:0];
            end
        end
    end

    // Read mux; summary bits 7..3 and unused fields read zero
    always_comb begin
        rd_byte = 8'h00;
        rd_ok = 1'b1;
        ist_rd = 1'b0;
        if (s_axi_araddr_i == ADDR_PWR) begin
            rd_byte = {1'b0, pwr_ff};
        end else if (s_axi_araddr_i == ADDR_SUM) begin
            rd_byte = {5'h00, sum_ff};
        end else if (s_axi_araddr_i == ADDR_FMT) begin
            rd_byte = {1'b0, fmt_ff};
        end else if (s_axi_araddr_i == ADDR_CLK) begin
            rd_byte = {4'h0, clk_ff};
        end else if (s_axi_araddr_i == ADDR_IST) begin
            rd_byte = {5'h00, ist_ff};
            ist_rd = 1'b1;
        end else if (s_axi_araddr_i == ADDR_IMSK) begin
            rd_byte = {5'h00, imsk_ff};
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ar_rdy_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else begin
            if (ar_hs) begin
                ar_rdy_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= {24'h00_0000, rd_byte};
                rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_ff && s_axi_rready_i) begin
                rvalid_ff <= 1'b0;
                ar_rdy_ff <= 1'b1;
            end
        end
    end

    // Summary follows the detailed pending lines of each block
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sum_ff <= 3'h0;
            sum_prev_ff <= 3'h0;
        end else begin
            sum_ff <= {tx_irq_i, rx_irq_i, conv_irq_i};
            sum_prev_ff <= sum_ff;
        end
    end

    // Sticky status: a new rise wins over a clearing read
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ist_ff <= 3'h0;
            irq_ff <= 1'b0;
        end else begin
            ist_ff <= ((sw_rst || (ar_hs && ist_rd)) ? 3'h0 : ist_ff) | (sum_ff & ~sum_prev_ff);
            irq_ff <= |(ist_ff & imsk_ff);
        end
    end

    // Block enables: each bit gated by the global bit
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conv_run_ff <= 1'b0;
            rx_run_ff <= 1'b0;
            tx_run_ff <= 1'b0;
            pb_run_ff <= 1'b0;
            pa_run_ff <= 1'b0;
        end else begin
            conv_run_ff <= pwr_ff[PWR_CONV] && pwr_ff[PWR_ALL];
            rx_run_ff <= pwr_ff[PWR_RX] && pwr_ff[PWR_ALL];
            tx_run_ff <= pwr_ff[PWR_TX] && pwr_ff[PWR_ALL];
            pb_run_ff <= pwr_ff[PWR_PB] && pwr_ff[PWR_ALL];
            pa_run_ff <= pa_on;
        end
    end

    // Master clock selection; reserved code yields no edges
    always_comb begin
        case (gcpa_clk_src_t'(clk_ff[CLK_SRC_LSB +: 2]))
            GCPA_SRC_MCLK: nxt_src = mclk_i;
            GCPA_SRC_RECEIVER_CLOCK_INPUT: nxt_src = receiver_clock_input_i;
            GCPA_SRC_RECOV: nxt_src = recovered_clock_output_i;
            default: nxt_src = 1'b0;
        endcase
    end

    assign mclk_edge = src_lvl_ff && !src_prev_ff;
    // Half bit period in master clocks is divider/128
    assign half_max = {1'b0, clk_ff[CLK_DIV_LSB +: 2]} + 3'h1;

    // Master clock must be well below half the core rate to be seen
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_lvl_ff <= 1'b0;
            src_prev_ff <= 1'b0;
            hb_cnt_ff <= 3'h0;
            bck_ff <= 1'b0;
            bit_cnt_ff <= '0;
        end else if (!(pa_on && pa_master) || sw_rst) begin
            src_lvl_ff <= nxt_src;
            src_prev_ff <= src_lvl_ff;
            hb_cnt_ff <= 3'h0;
            bck_ff <= 1'b0;
            bit_cnt_ff <= '0;
        end else begin
            src_lvl_ff <= nxt_src;
            src_prev_ff <= src_lvl_ff;
            if (mclk_edge) begin
                if (hb_cnt_ff >= half_max - 3'h1) begin
                    hb_cnt_ff <= 3'h0;
                    bck_ff <= !bck_ff;
                    if (bck_ff) begin
                        bit_cnt_ff <= bit_cnt_ff + BIT_CNT_W'(1);
                    end
                end else begin
                    hb_cnt_ff <= hb_cnt_ff + 3'h1;
                end
            end
        end
    end

    // Output source; disabled sources read as low
    always_comb begin
        case (gcpa_out_sel_t'(fmt_ff[FMT_SEL_LSB +: 2]))
            GCPA_OUT_LOOP: nxt_sdo = port_a_serial_in_i;
            GCPA_OUT_PORTB: nxt_sdo = port_b_serial_in_i && pb_run_ff;
            GCPA_OUT_RX: nxt_sdo = rx_data_i && rx_run_ff;
            default: nxt_sdo = conv_data_i && conv_run_ff;
        endcase
    end

    // Port A pins; slave mode leaves both clocks undriven
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdo_ff <= 1'b0;
            frame_o_ff <= 1'b0;
            bck_o_ff <= 1'b0;
            frame_oen_ff <= 1'b1;
            bck_oen_ff <= 1'b1;
        end else begin
            sdo_ff <= pa_on && !fmt_ff[FMT_MUTE] && nxt_sdo;
            frame_o_ff <= pa_on && pa_master && bit_cnt_ff[FRAME_BIT];
            bck_o_ff <= pa_on && pa_master && bck_ff;
            frame_oen_ff <= !pa_master;
            bck_oen_ff <= !pa_master;
        end
    end

    assign s_axi_awready_o = aw_rdy_ff;
    assign s_axi_wready_o = w_rdy_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_arready_o = ar_rdy_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rdata_o = rdata_ff;
    assign s_axi_rresp_o = rresp_ff;
    // Framing logic uses this for both directions
    assign port_a_format_o = fmt_ff[FMT_LSB +: 3];
    assign port_a_serial_out_o = sdo_ff;
    assign port_a_frame_clock_o = frame_o_ff;
    assign port_a_bit_clock_o = bck_o_ff;
    assign port_a_frame_clock_oe_n_o = frame_oen_ff;
    assign port_a_bit_clock_oe_n_o = bck_oen_ff;
    assign converter_run_enable_o = conv_run_ff;
    assign receiver_run_enable_o = rx_run_ff;
    assign transmitter_run_enable_o = tx_run_ff;
    assign port_b_run_enable_o = pb_run_ff;
    assign port_a_run_enable_o = pa_run_ff;
    assign irq_o = irq_ff;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_RX_OFF: assert property (!(pwr_ff[PWR_RX] && pwr_ff[PWR_ALL]) |=> !receiver_run_enable_o)
        else $error("receiver enabled while powered down");
    AST_TX_OFF: assert property (!pwr_ff[PWR_TX] |=> !transmitter_run_enable_o)
        else $error("transmitter enabled while powered down");
    AST_PB_OFF: assert property (!pwr_ff[PWR_PB] |=> !port_b_run_enable_o)
        else $error("port B enabled while powered down");
    AST_PA_OFF: assert property (!pa_on |=> !port_a_serial_out_o
        && !port_a_frame_clock_o && !port_a_bit_clock_o)
        else $error("port A output high while powered down");
    AST_ALL_OFF: assert property (!pwr_ff[PWR_ALL]
        |=> {conv_run_ff, rx_run_ff, tx_run_ff, pb_run_ff, pa_run_ff} == 5'h00)
        else $error("block enabled under global power down");
    AST_SRST: assert property (sw_rst |=> pwr_ff == PWR_RST && fmt_ff == FMT_RST && clk_ff == CLK_RST)
        else $error("soft reset left a register changed");
    AST_SUM_RD: assert property (ar_hs && s_axi_araddr_i == ADDR_SUM
        |=> s_axi_rvalid_o && s_axi_rdata_o[31:3] == 29'h0)
        else $error("summary upper bits not zero");
    AST_MASTER: assert property (pa_master |=> !port_a_frame_clock_oe_n_o ##0 !port_a_bit_clock_oe_n_o)
        else $error("master mode clocks not driven");
    AST_MUTE: assert property (fmt_ff[FMT_MUTE] |=> !port_a_serial_out_o)
        else $error("muted output high");
    AST_BIT_RATIO: assert property (pa_on && pa_master && $changed(bit_cnt_ff)
        |-> $past(bck_ff) && !bck_ff)
        else $error("frame advanced off a bit clock fall");
    AST_LOOPBACK: assert property (pa_on && !fmt_ff[FMT_MUTE] && fmt_ff[FMT_SEL_LSB +: 2] == 2'b00
        |=> port_a_serial_out_o == $past(port_a_serial_in_i))
        else $error("loopback output does not follow port A input");
    AST_SLAVE: assert property (!pa_master |=> port_a_frame_clock_oe_n_o && port_a_bit_clock_oe_n_o
        && !port_a_frame_clock_o && !port_a_bit_clock_o)
        else $error("slave mode drives port A clocks");
    AST_RSVD_SRC: assert property (clk_ff[CLK_SRC_LSB +: 2] == 2'b11 |=> !mclk_edge)
        else $error("reserved clock source produced an edge");
    AST_SUMMARY: assert property (##1 sum_ff == $past({tx_irq_i, rx_irq_i, conv_irq_i}))
        else $error("summary does not follow sources");
endmodule

/* File: dv/gcpa_audio_peer.sv */
// Far-side audio device on port A: master clock, slave-mode port clocks and data
`timescale 1ns/1ps
module gcpa_audio_peer (
    output logic mclk_o,
    output logic frame_clock_o,
    output logic bit_clock_o,
    output logic serial_o
);
    logic [5:0] bit_cnt_ff = 6'h00;
    logic [7:0] pattern_ff = 8'h5b;
    // Offset from core edges so sampling never races a toggle
    initial begin
        mclk_o = 1'b0;
        #1.5;
        forever #8 mclk_o = ~mclk_o;
    end
    initial begin
        bit_clock_o = 1'b0;
        #1.5;
        forever #32 bit_clock_o = ~bit_clock_o;
    end
    always @(negedge bit_clock_o) begin
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
        pattern_ff <= {pattern_ff[6:0], pattern_ff[7]};
    end
    assign frame_clock_o = bit_cnt_ff[5];
    assign serial_o = pattern_ff[7];
endmodule

/* File: dv/global_control_and_port_a_config_tb.sv */
// Self-checking bench for the global control and port A block
`timescale 1ns/1ps
module global_control_and_port_a_config_tb import gcpa_pkg::*; ;
    logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic cirq = 1'b0, rirq = 1'b0, tirq = 1'b0, rxck = 1'b0, rcck = 1'b0, sb = 1'b0, sdx = 1'b0, sdc = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] ws = 4'h1;
    logic awr, wr, bv, arr, rv, irq, mclk, sin, fin, bin, fo, foe_n, bo, boe_n, so, pc, prx, ptx, ppb, ppa;
    logic [1:0] br, rr;
    logic [31:0] rd;
    logic [2:0] fmt;
    logic [4:0] runv;
    int err_count = 0;
    int num_checks = 0;
    assign runv = {ppa, ppb, ptx, prx, pc};

    gcpa_ctrl gcpa_ctrl_inst (.core_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
        .conv_irq_i(cirq), .rx_irq_i(rirq), .tx_irq_i(tirq), .mclk_i(mclk), .receiver_clock_input_i(rxck),
        .recovered_clock_output_i(rcck), .port_a_serial_in_i(sin), .port_b_serial_in_i(sb),
        .rx_data_i(sdx), .conv_data_i(sdc), .port_a_frame_clock_i(fin), .port_a_bit_clock_i(bin),
        .port_a_frame_clock_o(fo), .port_a_frame_clock_oe_n_o(foe_n), .port_a_bit_clock_o(bo),
        .port_a_bit_clock_oe_n_o(boe_n), .port_a_serial_out_o(so), .port_a_format_o(fmt),
        .converter_run_enable_o(pc), .receiver_run_enable_o(prx), .transmitter_run_enable_o(ptx),
        .port_b_run_enable_o(ppb), .port_a_run_enable_o(ppa), .irq_o(irq));
    gcpa_audio_peer gcpa_audio_peer_inst (.mclk_o(mclk), .frame_clock_o(fin), .bit_clock_o(bin),
        .serial_o(sin));

    initial begin
        forever #2 clk = ~clk;
    end
    // Candidate master clocks, 3 and 5 core cycles, so the core oversamples them
    initial #1.5 forever #6 rxck = ~rxck;
    initial #1.5 forever #10 rcck = ~rcck;

    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected at %0t: %s seen %0h wanted %0h", $time, m, s, e);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic hang();
        err_count++;
        $display("unexpected at %0t: bus wait ran out", $time);
        complete_run();
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        awa <= a;
        awv <= 1'b1;
        wd <= {24'h0, d};
        wv <= 1'b1;
        bry <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (awv === 1'b1 && awr === 1'b1) awv <= 1'b0;
            if (wv === 1'b1 && wr === 1'b1) wv <= 1'b0;
            if (bv === 1'b1) break;
        end
        if (n == 64) hang();
        chk(32'(br), 32'(er), "write response");
        bry <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string m);
        int n;
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (arv === 1'b1 && arr === 1'b1) arv <= 1'b0;
            if (rv === 1'b1) break;
        end
        if (n == 64) hang();
        chk(32'(rr), 32'(er), m);
        if (er == RESP_OKAY) chk(rd, e, m);
        rry <= 1'b0;
        @(posedge clk);
    endtask
    // First frame after a change may be short, so time the second full one
    task automatic frame_of(output int p, output int bits);
        logic pf, pb;
        int edges, t0;
        edges = 0;
        p = 0;
        bits = 0;
        pf = 1'b1;
        pb = 1'b1;
        for (int n = 0; n < 8000 && edges < 3; n++) begin
            @(posedge clk);
            if (edges == 2 && bo === 1'b1 && pb === 1'b0) bits++;
            if (fo === 1'b1 && pf === 1'b0) begin
                edges++;
                if (edges == 3) p = n - t0;
                t0 = n;
            end
            pf = fo;
            pb = bo;
        end
    endtask

    task automatic t_regs();
        rd_chk(ADDR_PWR, 32'h0, RESP_OKAY, "power default");
        rd_chk(ADDR_FMT, 32'h0, RESP_OKAY, "format default");
        rd_chk(ADDR_CLK, 32'h0, RESP_OKAY, "clock default");
        chk(32'({runv, so, fo, bo, foe_n, boe_n, irq}), 32'h6, "idle pins");
        for (int c = 0; c < 8; c++) begin
            wr_reg(ADDR_FMT, 8'(c), RESP_OKAY);
            repeat (2) @(posedge clk);
            chk(32'(fmt), 32'(c), "format pin");
            rd_chk(ADDR_FMT, 32'(c), RESP_OKAY, "format readback");
        end
        wr_reg(ADDR_CLK, 8'h0f, RESP_OKAY);
        wr_reg(ADDR_IMSK, 8'h07, RESP_OKAY);
        rd_chk(ADDR_CLK, 32'hf, RESP_OKAY, "clock readback");
        ws <= 4'h0;
        wr_reg(ADDR_CLK, 8'h00, RESP_OKAY);
        ws <= 4'h1;
        rd_chk(ADDR_CLK, 32'hf, RESP_OKAY, "strobe off keeps value");
        wr_reg(ADDR_PWR, 8'hbf, RESP_OKAY);
        rd_chk(ADDR_PWR, 32'h0, RESP_OKAY, "power after soft reset");
        rd_chk(ADDR_FMT, 32'h0, RESP_OKAY, "format after soft reset");
        rd_chk(ADDR_CLK, 32'h0, RESP_OKAY, "clock after soft reset");
        rd_chk(ADDR_IMSK, 32'h0, RESP_OKAY, "mask after soft reset");
        wr_reg(8'h40, 8'h01, RESP_SLVERR);
        rd_chk(8'h40, 32'h0, RESP_SLVERR, "unmapped read");
        $display("test registers done");
    endtask

    task automatic t_route();
        logic pbk;
        int k;
        wr_reg(ADDR_PWR, 8'h1f, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(32'(runv), 32'h0, "global off");
        wr_reg(ADDR_PWR, 8'h35, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(32'(runv), 32'h15, "single blocks");
        sb <= 1'b1;
        wr_reg(ADDR_PWR, 8'h2f, RESP_OKAY);
        wr_reg(ADDR_FMT, 8'h18, RESP_OKAY);
        repeat (300) @(posedge clk);
        chk(32'({so, fo, bo}), 32'h0, "port A off");
        wr_reg(ADDR_PWR, 8'h3f, RESP_OKAY);
        for (int s = 1; s < 4; s++) begin
            sb <= 1'(s == 1);
            sdx <= 1'(s == 2);
            sdc <= 1'(s == 3);
            // Converter leg runs right-justified 24-bit; word length matched elsewhere
            wr_reg(ADDR_FMT, 8'(s * 16 + ((s == 3) ? 7 : 0)), RESP_OKAY);
            repeat (3) @(posedge clk);
            chk(32'(so), 32'h1, "routed source");
            wr_reg(ADDR_FMT, 8'(s * 16 + 64), RESP_OKAY);
            repeat (3) @(posedge clk);
            chk(32'(so), 32'h0, "muted");
        end
        wr_reg(ADDR_FMT, 8'h00, RESP_OKAY);
        repeat (3) begin
            pbk = bin;
            for (k = 0; k < 40; k++) begin
                @(posedge clk);
                if (pbk === 1'b1 && bin === 1'b0) break;
                pbk = bin;
            end
            if (k == 40) hang();
            repeat (8) @(posedge clk);
            chk(32'(so), 32'(sin), "loopback");
        end
        $display("test routing done");
    endtask

    task automatic t_clocks();
        logic [7:0] code [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c};
        int fr [7] = '{512, 1024, 1536, 2048, 384, 640, 0};
        int p, bits;
        wr_reg(ADDR_FMT, 8'h08, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(32'({foe_n, boe_n}), 32'h0, "master drives clocks");
        for (int i = 0; i < 7; i++) begin
            wr_reg(ADDR_CLK, code[i], RESP_OKAY);
            frame_of(p, bits);
            chk(32'(p), 32'(fr[i]), "frame period");
            chk(32'(bits), (i < 6) ? 32'd64 : 32'd0, "bits per frame");
        end
        wr_reg(ADDR_FMT, 8'h00, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(32'({foe_n, boe_n}), 32'h3, "slave listens");
        $display("test clocks done");
    endtask

    task automatic t_irq();
        wr_reg(ADDR_IMSK, 8'h01, RESP_OKAY);
        rirq <= 1'b1;
        repeat (4) @(posedge clk);
        chk(32'(irq), 32'h0, "masked source");
        rd_chk(ADDR_SUM, 32'h2, RESP_OKAY, "receiver summary");
        cirq <= 1'b1;
        tirq <= 1'b1;
        repeat (4) @(posedge clk);
        chk(32'(irq), 32'h1, "unmasked source");
        rd_chk(ADDR_IST, 32'h7, RESP_OKAY, "event status");
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0, "status cleared");
        wr_reg(ADDR_SUM, 8'h00, RESP_OKAY);
        rd_chk(ADDR_SUM, 32'h7, RESP_OKAY, "summary held");
        cirq <= 1'b0;
        rirq <= 1'b0;
        tirq <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(ADDR_SUM, 32'h0, RESP_OKAY, "summary cleared");
        $display("test interrupts done");
    endtask

    // Pin reset in mid-run must behave like power-up
    task automatic t_reset();
        wr_reg(ADDR_FMT, 8'h48, RESP_OKAY);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'({runv, so, fo, bo, foe_n, boe_n, irq}), 32'h6, "pins in reset");
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(ADDR_PWR, 32'h0, RESP_OKAY, "power after pin reset");
        rd_chk(ADDR_FMT, 32'h0, RESP_OKAY, "format after pin reset");
        chk(32'({foe_n, boe_n, so}), 32'h6, "pins after pin reset");
        $display("test reset done");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_route();
        t_clocks();
        t_irq();
        t_reset();
        complete_run();
    end
endmodule
